// *** hdl/lsef_cfg.svh ***
`ifndef LSEF_CFG_SVH
`define LSEF_CFG_SVH

// register indices, byte address is four times the index
`define LSEF_IDX_CTRL       4'h8
`define LSEF_IDX_STAT       4'h9
`define LSEF_IDX_ERR        4'ha

// control register bit positions
`define LSEF_CB_STOP        7
`define LSEF_CB_SLEEP       6
`define LSEF_CB_TXRX        5
`define LSEF_CB_ACK         4
`define LSEF_CB_IRQCLR      3
`define LSEF_CB_FLTCLR      2
`define LSEF_CB_WUPREQ      1
`define LSEF_CB_STREQ       0

// reset values
`define LSEF_RST_CTRL       8'h00
`define LSEF_RST_STAT       8'h00
`define LSEF_RST_ERR        5'h00
`define LSEF_ERR_PAD        3'h0

// bus answers
`define LSEF_RESP_OKAY      2'h0
`define LSEF_RESP_SLVERR    2'h2

// timing
`define LSEF_CLK_PERIOD_NS  10
`define LSEF_NS_PER_S       64'd1000000000
`define LSEF_NS_PER_US      64'd1000
`define LSEF_IDLE_TIMEOUT_S 4
`define LSEF_FRAME_MAX_US   10000

`endif

// *** hdl/lsef_pkg.sv ***
package lsef_pkg;

    // frame tracking states
    typedef enum logic [1:0] {
        LSEF_FRM_IDLE,
        LSEF_FRM_BUSY,
        LSEF_FRM_BLOCKED
    } lsef_frm_e;

    typedef logic [31:0] lsef_cnt_t;
    typedef logic [7:0]  lsef_byte_t;
    typedef logic [4:0]  lsef_errs_t;

    // synchroniser state
    typedef struct packed {
        logic [2:0] ff;
        logic       q;
    } lsef_sync_s;

    // whole state of the flag block
    typedef struct packed {
        lsef_frm_e  frm;
        lsef_cnt_t  idle_cnt;
        lsef_cnt_t  frm_cnt;
        logic       sleep;
        logic       txrx;
        logic       ack;
        logic       wup_req;
        logic       st_req;
        logic       blocked;
        logic       active;
        logic       idle_to;
        logic       abort;
        logic       dreq;
        logic       irq;
        logic       err;
        logic       wake;
        logic       wake_rx;
        logic       done;
        logic       ack_due;
        lsef_errs_t errs;
        logic       aw_got;
        lsef_byte_t aw_addr;
        logic       w_got;
        lsef_byte_t wdata;
        logic       wen0;
        logic       awready;
        logic       wready;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arready;
        logic       rvalid;
        lsef_byte_t rdata;
        logic [1:0] rresp;
    } lsef_st_s;

endpackage

// *** hdl/lsef_sync.sv ***
// three-stage input synchroniser, output moves once stages two and three agree
module lsef_sync
#(
    parameter bit RST_VAL = 1'b1
)
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // asynchronous level in, clean level out
    input  wire logic din,
    output      logic dout
);
    import lsef_pkg::*;

    lsef_sync_s st_r;
    lsef_sync_s st_nxt;

    // first stage feeds only the second
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.ff = {st_r.ff[1:0], din};
        if (st_r.ff[1] == st_r.ff[2])
        begin
            st_nxt.q = st_r.ff[2];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '{ff: {3{RST_VAL}}, q: RST_VAL};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.q;

endmodule // lsef_sync

// *** hdl/lsef_top.sv ***
// Design decision made here: register access over AXI4-Lite.
`include "lsef_cfg.svh"

// Function
// - active flag high while bus activity or a frame is seen
// - slave: idle timeout flag after four seconds without activity, not asleep
// - slave: abort set on break during frame or on stop request
// - abort cleared by a break that interrupts no frame
// - slave: data request set when identifier received, held until break or data acknowledge
// - interrupt pending held until software writes the interrupt clear strobe
// - general error set on any error, cleared only by fault clear strobe
// - wakeup flag set while sending or after receiving wakeup
// - completion flag cleared at frame start, set when frame completes
// - slave: sync field edge tolerance failure sets sync error
// - slave: identifier parity failure sets parity error
// - master: missing slave response sets timeout error
// - slave: expected data never sent sets timeout error
// - frame exceeding maximum length sets timeout error
// - received checksum mismatch sets checksum error
// - sampled bus bit differing from driven bit sets bit error
// - error register upper three bits read zero, writes ignored
// - fault clear strobe clears all error flags and reads zero
// - slave: stop strobe blocks processing until next break
// - data acknowledge bit clears itself automatically
module lsef_top
#(
    parameter int unsigned IDLE_CYC  = 32'(64'(`LSEF_IDLE_TIMEOUT_S) * `LSEF_NS_PER_S / 64'(`LSEF_CLK_PERIOD_NS)),
    parameter int unsigned FRAME_CYC = 32'(64'(`LSEF_FRAME_MAX_US) * `LSEF_NS_PER_US / 64'(`LSEF_CLK_PERIOD_NS))
)
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write channels
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read channels
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // bus receive pin, asynchronous
    input  wire logic        lin_rx,
    // engine inputs, same clock; mode and transmit lines are levels, events are one-cycle pulses
    input  wire logic        master_mode,
    input  wire logic        ev_sync_break,
    input  wire logic        ev_id_rx,
    input  wire logic        ev_frame_done,
    input  wire logic        ev_sync_err,
    input  wire logic        ev_parity_err,
    input  wire logic        ev_resp_missing,
    input  wire logic        ev_data_missing,
    input  wire logic        ev_first_byte_done,
    input  wire logic        ev_checksum_err,
    input  wire logic        ev_wakeup_rx,
    input  wire logic        tx_active,
    input  wire logic        wakeup_tx_active,
    input  wire logic        bit_sample,
    input  wire logic        tx_bit,
    // controls back to the protocol engine
    output      logic        start_req,
    output      logic        wakeup_req,
    output      logic        txrx_sel,
    output      logic        sleep_sel,
    output      logic        data_handled_ack,
    output      logic        comm_blocked
);
    import lsef_pkg::*;

    localparam lsef_cnt_t IDLE_LAST  = lsef_cnt_t'(IDLE_CYC - 1);
    localparam lsef_cnt_t FRAME_LAST = lsef_cnt_t'(FRAME_CYC - 1);

    lsef_st_s   st_r;
    lsef_st_s   st_nxt;
    logic       rx_s;
    logic       slave;
    logic       proc_ok;
    logic       wr_fire;
    logic       wr_ok;
    logic       wr_ctrl;
    logic       stop_w;
    logic       iclr_w;
    logic       fclr_w;
    logic       ack_w;
    logic       id_set;
    logic       frm_over;
    logic       ack_miss;
    lsef_errs_t err_ev;
    logic       abort_set;
    logic       rd_ok;
    lsef_byte_t rd_val;

    // pin level is only trusted after the three-stage filter
    lsef_sync #(
        .RST_VAL (1'b1)
    ) u_rx_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (lin_rx),
        .dout    (rx_s)
    );

    // write decode, only byte lane 0 carries register bits
    assign slave   = !master_mode;
    assign proc_ok = (st_r.frm != LSEF_FRM_BLOCKED);
    assign wr_fire = st_r.aw_got && st_r.w_got;
    assign wr_ok   = (st_r.aw_addr[1:0] == 2'h0) && (st_r.aw_addr[7:6] == 2'h0) &&
                     (st_r.aw_addr[5:2] >= `LSEF_IDX_CTRL) && (st_r.aw_addr[5:2] <= `LSEF_IDX_ERR);
    assign wr_ctrl = wr_fire && wr_ok && st_r.wen0 && (st_r.aw_addr[5:2] == `LSEF_IDX_CTRL);
    assign stop_w  = wr_ctrl && slave && st_r.wdata[`LSEF_CB_STOP];
    assign iclr_w  = wr_ctrl && st_r.wdata[`LSEF_CB_IRQCLR];
    assign fclr_w  = wr_ctrl && st_r.wdata[`LSEF_CB_FLTCLR];
    assign ack_w   = wr_ctrl && st_r.wdata[`LSEF_CB_ACK];

    // error causes; blocked processing hides engine events except bit error and master response timeout
    assign id_set   = slave && proc_ok && ev_id_rx;
    assign frm_over = (st_r.frm == LSEF_FRM_BUSY) && (st_r.frm_cnt == FRAME_LAST);
    assign ack_miss = slave && proc_ok && ev_first_byte_done && st_r.ack_due && !ack_w && !stop_w;
    assign err_ev[4] = slave && proc_ok && ev_sync_err;
    assign err_ev[3] = slave && proc_ok && ev_parity_err;
    assign err_ev[2] = (master_mode && ev_resp_missing) ||
                       (slave && proc_ok && ev_data_missing) ||
                       frm_over || ack_miss;
    assign err_ev[1] = proc_ok && ev_checksum_err;
    assign err_ev[0] = tx_active && bit_sample && (rx_s != tx_bit);
    assign abort_set = slave && ((ev_sync_break && st_r.frm == LSEF_FRM_BUSY) || stop_w);

    // read mux; strobe bits read zero, error pad bits read zero
    assign rd_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[7:6] == 2'h0) &&
                   (s_axi_araddr[5:2] >= `LSEF_IDX_CTRL) && (s_axi_araddr[5:2] <= `LSEF_IDX_ERR);
    always_comb
    begin
        case (s_axi_araddr[5:2])
            `LSEF_IDX_CTRL: rd_val = {1'b0, st_r.sleep, st_r.txrx, st_r.ack, 2'h0, st_r.wup_req, st_r.st_req};
            `LSEF_IDX_STAT: rd_val = {st_r.active, st_r.idle_to, st_r.abort, st_r.dreq,
                                      st_r.irq, st_r.err, st_r.wake, st_r.done};
            `LSEF_IDX_ERR:  rd_val = {`LSEF_ERR_PAD, st_r.errs};
            default:        rd_val = 8'h00;
        endcase
    end

    // next state of every flag, counter and bus channel
    always_comb
    begin
        st_nxt = st_r;

        // frame tracking; a stop request wins over everything else
        case (st_r.frm)
            LSEF_FRM_IDLE:
            begin
                if (ev_sync_break)
                begin
                    st_nxt.frm     = LSEF_FRM_BUSY;
                    st_nxt.frm_cnt = 32'h0;
                end
            end
            LSEF_FRM_BUSY:
            begin
                st_nxt.frm_cnt = st_r.frm_cnt + 32'h1;
                if (ev_sync_break)
                begin
                    st_nxt.frm_cnt = 32'h0;
                end
                else if (ev_frame_done || err_ev[2])
                begin
                    st_nxt.frm = LSEF_FRM_IDLE;
                end
            end
            LSEF_FRM_BLOCKED:
            begin
                if (ev_sync_break)
                begin
                    st_nxt.frm     = LSEF_FRM_BUSY;
                    st_nxt.frm_cnt = 32'h0;
                end
            end
            default:
            begin
                st_nxt.frm = LSEF_FRM_IDLE;
            end
        endcase
        if (stop_w)
        begin
            st_nxt.frm = LSEF_FRM_BLOCKED;
        end
        st_nxt.blocked = (st_nxt.frm == LSEF_FRM_BLOCKED);

        // idle timer runs only for an idle, awake slave on a recessive bus
        if (!rx_s || master_mode || st_r.sleep || st_r.frm != LSEF_FRM_IDLE)
        begin
            st_nxt.idle_cnt = 32'h0;
            st_nxt.idle_to  = 1'b0;
        end
        else if (st_r.idle_cnt != IDLE_LAST)
        begin
            st_nxt.idle_cnt = st_r.idle_cnt + 32'h1;
        end
        else
        begin
            st_nxt.idle_to = 1'b1;
        end

        // status flags
        st_nxt.active = (st_r.frm == LSEF_FRM_BUSY) || !rx_s;
        if (abort_set)
        begin
            st_nxt.abort = 1'b1;
        end
        else if (ev_sync_break)
        begin
            st_nxt.abort = 1'b0;
        end
        st_nxt.dreq    = id_set || (st_r.dreq && !ev_sync_break && !ack_w);
        st_nxt.ack_due = id_set || (st_r.ack_due && !ev_sync_break && !ack_w && !stop_w && !ev_first_byte_done);
        st_nxt.ack     = ack_w;
        st_nxt.wake_rx = ev_wakeup_rx || (st_r.wake_rx && !ev_sync_break);
        st_nxt.wake    = wakeup_tx_active || st_nxt.wake_rx;
        st_nxt.done    = (proc_ok && ev_frame_done) || (st_r.done && !ev_sync_break);

        // sticky errors; a new cause beats a clear in the same cycle
        st_nxt.errs = (fclr_w ? `LSEF_RST_ERR : st_r.errs) | err_ev;
        st_nxt.err  = (fclr_w ? 1'b0 : st_r.err) | (|err_ev);
        st_nxt.irq  = ev_frame_done || (|err_ev) || id_set || ev_wakeup_rx || abort_set ||
                      (st_nxt.idle_to && !st_r.idle_to) || (st_r.irq && !iclr_w);

        // control bits stored for the engine
        if (wr_ctrl)
        begin
            st_nxt.sleep   = st_r.wdata[`LSEF_CB_SLEEP];
            st_nxt.txrx    = st_r.wdata[`LSEF_CB_TXRX];
            st_nxt.wup_req = st_r.wdata[`LSEF_CB_WUPREQ];
            st_nxt.st_req  = st_r.wdata[`LSEF_CB_STREQ];
        end
        else
        begin
            if (wakeup_tx_active)
            begin
                st_nxt.wup_req = 1'b0;
            end
            if (ev_frame_done || (|err_ev))
            begin
                st_nxt.st_req = 1'b0;
            end
        end

        // write address and data taken in either order
        if (s_axi_awvalid && st_r.awready)
        begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready)
        begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata[7:0];
            st_nxt.wen0  = s_axi_wstrb[0];
        end
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end
        if (wr_fire)
        begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = wr_ok ? `LSEF_RESP_OKAY : `LSEF_RESP_SLVERR;
        end

        // read answers the cycle after the address is taken
        if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_val;
            st_nxt.rresp  = rd_ok ? `LSEF_RESP_OKAY : `LSEF_RESP_SLVERR;
        end

        // one write and one read in flight at most
        st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
        st_nxt.arready = !st_nxt.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r         <= '0;
            st_r.frm     <= LSEF_FRM_IDLE;
            st_r.awready <= 1'b1;
            st_r.wready  <= 1'b1;
            st_r.arready <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready    = st_r.awready;
    assign s_axi_wready     = st_r.wready;
    assign s_axi_bvalid     = st_r.bvalid;
    assign s_axi_bresp      = st_r.bresp;
    assign s_axi_arready    = st_r.arready;
    assign s_axi_rvalid     = st_r.rvalid;
    assign s_axi_rresp      = st_r.rresp;
    assign s_axi_rdata      = {24'h0, st_r.rdata};
    assign start_req        = st_r.st_req;
    assign wakeup_req       = st_r.wup_req;
    assign txrx_sel         = st_r.txrx;
    assign sleep_sel        = st_r.sleep;
    assign data_handled_ack = st_r.ack;
    assign comm_blocked     = st_r.blocked;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence brk_no_frame;
        slave && ev_sync_break && st_r.frm != LSEF_FRM_BUSY && !stop_w;
    endsequence

    write_answer_a: assert property (wr_both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer late");
    abort_break_a: assert property (slave && ev_sync_break && st_r.frm == LSEF_FRM_BUSY |=> st_r.abort)
        else $error("abort not set by break");
    abort_clear_a: assert property (brk_no_frame |=> !st_r.abort)
        else $error("abort not cleared");
    done_clear_a: assert property (ev_sync_break && !ev_frame_done |=> !st_r.done)
        else $error("done kept over break");
    irq_hold_a: assert property (st_r.irq && !iclr_w |=> st_r.irq)
        else $error("irq lost without clear");
    err_general_a: assert property (st_r.errs != 5'h0 |-> st_r.err)
        else $error("error flag missing");
    fault_clear_a: assert property (fclr_w && err_ev == 5'h0 |=> st_r.errs == 5'h0 && !st_r.err)
        else $error("errors not cleared");
    bit_error_a: assert property (tx_active && bit_sample && rx_s != tx_bit |=> st_r.errs[0])
        else $error("bit error missed");
    ack_pulse_a: assert property (st_r.ack |=> !st_r.ack)
        else $error("ack not self cleared");
    stop_block_a: assert property (stop_w ##1 !ev_sync_break |=> comm_blocked)
        else $error("stop did not block");
    idle_flag_a: assert property (st_r.idle_to |-> slave || $past(slave))
        else $error("idle flag outside slave");
    wake_send_a: assert property (wakeup_tx_active |=> st_r.wake) else $error("wake flag missed");

endmodule // lsef_top

// *** dv/lsef_node_model.sv ***
// stands in for the protocol engine and the other bus nodes
module lsef_node_model
(
    // bench commands; index 11 stands for a wakeup transmission
    input  wire logic [3:0]  evt_sel,
    input  wire logic        evt_go,
    input  wire logic        bus_lvl,
    // event pulses, index 10 is the bit sample strobe
    output      logic [10:0] ev,
    // bus pin and transmit monitor
    output      logic        lin_rx,
    output      logic        tx_active,
    output      logic        tx_bit,
    output      logic        wakeup_tx_active
);
    timeunit 1ns;
    timeprecision 1ps;

    // one event per command; the bit strobe drives dominant against a recessive bus
    assign ev               = evt_go ? (11'h001 << evt_sel) : 11'h000;
    assign tx_active        = evt_go && (evt_sel == 4'ha);
    assign tx_bit           = !tx_active;
    assign wakeup_tx_active = evt_go && (evt_sel == 4'hb);
    // bus pin follows the bench level, recessive unless the bench pulls it dominant
    assign lin_rx           = bus_lvl;
endmodule // lsef_node_model

// *** dv/lsef_top_test.sv ***
`include "lsef_cfg.svh"

module lsef_top_test;
    import lsef_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // short counts keep the run brief
    localparam int IDLE = 50;
    localparam int FRAME = 200;
    localparam logic [7:0] A_CTRL = 8'(`LSEF_IDX_CTRL) << 2;
    localparam logic [7:0] A_STAT = 8'(`LSEF_IDX_STAT) << 2;
    localparam logic [7:0] A_ERR = 8'(`LSEF_IDX_ERR) << 2;
    localparam logic [7:0] A_NONE = 8'h2c;

    typedef struct packed {
        logic [3:0] ev;
        logic       mm;
        lsef_byte_t stat;
        lsef_byte_t err;
    } lsef_row_s;

    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, lin_rx;
    logic        master_mode, tx_active, tx_bit, wakeup_tx_active, start_req, wakeup_req;
    logic        txrx_sel, sleep_sel, data_handled_ack, comm_blocked, evt_go, bus_lvl;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, evt_sel;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [10:0] ev;
    int          miscompares = 0;
    int          checks_done = 0;

    // event index, mode, status without active bit, error register
    lsef_row_s rows [11] = '{'{4'd2, 1'b0, 8'h09, 8'h00}, '{4'd1, 1'b0, 8'h18, 8'h00},
        '{4'd3, 1'b0, 8'h0c, 8'h10}, '{4'd4, 1'b0, 8'h0c, 8'h08}, '{4'd5, 1'b1, 8'h0c, 8'h04},
        '{4'd6, 1'b0, 8'h0c, 8'h04}, '{4'd8, 1'b0, 8'h0c, 8'h02}, '{4'd10, 1'b0, 8'h0c, 8'h01},
        '{4'd9, 1'b0, 8'h0a, 8'h00}, '{4'd5, 1'b0, 8'h00, 8'h00}, '{4'd6, 1'b1, 8'h00, 8'h00}};

    lsef_top #(.IDLE_CYC(IDLE), .FRAME_CYC(FRAME)) u_dut
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .lin_rx, .master_mode, .ev_sync_break(ev[0]), .ev_id_rx(ev[1]),
        .ev_frame_done(ev[2]), .ev_sync_err(ev[3]), .ev_parity_err(ev[4]), .ev_resp_missing(ev[5]),
        .ev_data_missing(ev[6]), .ev_first_byte_done(ev[7]), .ev_checksum_err(ev[8]),
        .ev_wakeup_rx(ev[9]), .tx_active, .wakeup_tx_active, .bit_sample(ev[10]), .tx_bit,
        .start_req, .wakeup_req, .txrx_sel, .sleep_sel, .data_handled_ack, .comm_blocked
    );

    lsef_node_model u_node (.evt_sel, .evt_go, .bus_lvl, .ev, .lin_rx, .tx_active, .tx_bit, .wakeup_tx_active);

    // free-running system clock
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [1:0] resp_for(input logic [7:0] a);
        return (a == A_CTRL || a == A_STAT || a == A_ERR) ? `LSEF_RESP_OKAY : `LSEF_RESP_SLVERR;
    endfunction

    // one write; address and data offered together, each dropped once taken
    task automatic reg_put(input logic [7:0] a, input lsef_byte_t d, input logic [3:0] st = 4'h1);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awprot <= a[4:2];
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {4{d}};
        s_axi_wstrb <= st;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(resp_for(a)));
    endtask

    // one read, compared under a mask; upper 24 bits must read zero
    task automatic reg_is(input logic [7:0] a, input lsef_byte_t mask, input lsef_byte_t exp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arprot <= a[4:2];
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata & {24'hffffff, mask}, {24'h0, exp});
        check(32'(s_axi_rresp), 32'(resp_for(a)));
    endtask

    // one-cycle engine event through the node model
    task automatic fire(input logic [3:0] idx);
        @(posedge aclk);
        evt_sel <= idx;
        evt_go <= 1'b1;
        @(posedge aclk);
        evt_go <= 1'b0;
    endtask

    // reset held two edges; mode settles with it
    task automatic restart(input logic mm);
        @(posedge aclk);
        aresetn <= 1'b0;
        master_mode <= mm;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // a hang counts against the run
    initial
    begin
        repeat (6000) @(posedge aclk);
        miscompares++;
        complete_run();
    end

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, master_mode, aresetn} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h1;
        {evt_sel, evt_go, bus_lvl} = 6'h01;
        // each event after a fresh reset and a break
        foreach (rows[i])
        begin
            restart(rows[i].mm);
            fire(4'h0);
            fire(rows[i].ev);
            reg_is(A_STAT, 8'h7f, rows[i].stat);
            reg_is(A_ERR, 8'hff, rows[i].err);
        end
        end_test("event table");
        // reset values, read-only writes, unmapped place
        restart(1'b0);
        reg_is(A_STAT, 8'hff, `LSEF_RST_STAT);
        reg_put(A_ERR, 8'hff);
        reg_is(A_ERR, 8'hff, 8'h00);
        reg_is(A_NONE, 8'hff, 8'h00);
        reg_put(A_NONE, 8'h04);
        end_test("reset and map");
        // fault clear leaves irq pending, irq clear then drops it
        restart(1'b0);
        fire(4'h0);
        fire(4'h3);
        reg_put(A_CTRL, 8'h04);
        reg_is(A_STAT, 8'h3f, 8'h08);
        reg_is(A_ERR, 8'hff, 8'h00);
        reg_put(A_CTRL, 8'h28);
        reg_is(A_STAT, 8'h3f, 8'h00);
        reg_is(A_CTRL, 8'hff, 8'h20);
        check(32'(txrx_sel), 32'h1);
        end_test("clear strobes");
        // break inside a frame aborts, break after completion clears it
        restart(1'b0);
        fire(4'h0);
        fire(4'h0);
        reg_is(A_STAT, 8'h3f, 8'h28);
        fire(4'h2);
        fire(4'h0);
        reg_is(A_STAT, 8'h3f, 8'h08);
        end_test("abort");
        // stop blocks identifiers until the next break
        restart(1'b0);
        reg_put(A_CTRL, 8'h80);
        fire(4'h1);
        reg_is(A_STAT, 8'h3f, 8'h28);
        check(32'(comm_blocked), 32'h1);
        fire(4'h0);
        @(posedge aclk);
        check(32'(comm_blocked), 32'h0);
        end_test("stop");
        // acknowledged request is quiet, unacknowledged one times out
        restart(1'b0);
        fire(4'h0);
        fire(4'h1);
        reg_put(A_CTRL, 8'h10);
        reg_is(A_STAT, 8'h3f, 8'h08);
        reg_is(A_CTRL, 8'h10, 8'h00);
        fire(4'h7);
        reg_is(A_ERR, 8'hff, 8'h00);
        restart(1'b0);
        fire(4'h0);
        fire(4'h1);
        fire(4'h7);
        reg_is(A_ERR, 8'hff, 8'h04);
        end_test("data ack");
        // frame left open past the length limit
        restart(1'b1);
        fire(4'h0);
        repeat (FRAME + 10) @(posedge aclk);
        reg_is(A_ERR, 8'hff, 8'h04);
        end_test("frame length");
        // quiet slave bus, then dominant activity
        restart(1'b0);
        repeat (IDLE + 10) @(posedge aclk);
        reg_is(A_STAT, 8'hff, 8'h48);
        @(posedge aclk);
        bus_lvl <= 1'b0;
        repeat (8) @(posedge aclk);
        reg_is(A_STAT, 8'h80, 8'h80);
        @(posedge aclk);
        bus_lvl <= 1'b1;
        end_test("bus activity");
        // control outputs, lane 0 strobe, sleep keeps the idle timer at zero
        restart(1'b0);
        reg_put(A_CTRL, 8'h53);
        check(32'(data_handled_ack), 32'h1);
        @(posedge aclk);
        check(32'(data_handled_ack), 32'h0);
        reg_put(A_CTRL, 8'h00, 4'he);
        check(32'({sleep_sel, wakeup_req, start_req}), 32'h7);
        repeat (IDLE + 10) @(posedge aclk);
        reg_is(A_STAT, 8'h40, 8'h00);
        fire(4'h2);
        fire(4'hb);
        @(posedge aclk);
        check(32'({wakeup_req, start_req}), 32'h0);
        end_test("control outputs");
        complete_run();
    end
endmodule // lsef_top_test
